// file: design/fdpos_pkg.sv
/*
 * Shared constants, state codes and pin bundles for the flexible disk
 * positioner and host port. Assumes a single 40 MHz system clock.
 */
package fdpos_pkg;

	// ==========================================================
	// timing
	localparam int CLK_HZ = 40_000_000;
	localparam int BIT_RATE_HZ = 375_000;
	// longest whole bit cell that fits the rate: rounds down
	localparam int BIT_CYC = CLK_HZ / BIT_RATE_HZ;
	localparam int CELL_CYC = BIT_CYC / 2;
	localparam int STEP_CYC_DEF = 1000;
	localparam int SETTLE_CYC_DEF = 2000;
	localparam int HEAD_LOAD_CYC_DEF = 1000;
	localparam int TMR_W = 16;

	// ==========================================================
	// cylinder geometry
	localparam int CYL_W = 7;
	localparam int CNT_W = 8;
	localparam logic [CYL_W-1:0] CYL_LAST = 7'h57;
	localparam logic [CYL_W-1:0] CYL_ZERO = 7'h00;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

	// ==========================================================
	// register port
	localparam int REG_AW = 4;
	localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
	localparam logic [REG_AW-1:0] REG_STAT = 4'h4;
	localparam int CTRL_SLAVE_BIT = 0;
	localparam int CTRL_RECAL_BIT = 1;
	localparam logic CTRL_SLAVE_RST = 1'b0;
	localparam int STAT_TGT_LSB = 8;
	localparam int STAT_READY_BIT = 16;
	localparam int STAT_SETTLED_BIT = 17;
	localparam int STAT_ILLEGAL_BIT = 18;
	localparam int STAT_BUSY_BIT = 19;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_RECAL = 3'b001,
		ST_IDLE = 3'b010,
		ST_STEP = 3'b011,
		ST_SETTLE = 3'b100
	} fdpos_state_e;

	typedef struct packed {
		logic unit_sel_n;
		logic head_sel_n;
		logic [CYL_W-1:0] cyl_n;
		logic seek_n;
		logic wr_en_n;
		logic wr_data_n;
		logic rd_en_n;
	} fdpos_host_in_s;

	typedef struct packed {
		logic ready_n;
		logic settled_n;
		logic wr_prot_n;
		logic index_n;
		logic sector_n;
		logic illegal_n;
		logic fault_n;
		logic data_clk_n;
		logic rd_data_n;
	} fdpos_host_out_s;

	typedef struct packed {
		logic disk_present;
		logic spindle_at_speed;
		logic track00;
		logic index_hole;
		logic sector_hole;
		logic protect_tab;
		logic mfm_rd;
	} fdpos_mech_in_s;

	typedef struct packed {
		logic step;
		logic step_up;
		logic head_load;
		logic head_side;
		logic write_gate;
		logic read_gate;
		logic mfm_wr;
	} fdpos_mech_out_s;

	localparam int IN_W = $bits(fdpos_host_in_s) + $bits(fdpos_mech_in_s);
	// synchroniser reset: host pins idle high, mechanism sensors idle low
	localparam logic [IN_W-1:0] SYNC_IDLE = {{$bits(fdpos_host_in_s){1'b1}},
		{$bits(fdpos_mech_in_s){1'b0}}};

endpackage

// file: design/fdpos_top.sv
/*
 * Host port and positioner control of one flexible disk drive: address
 * latch, range check, present-cylinder counter, stepping, recalibration,
 * settle timing, bit strobe and MFM coding toward the second unit.
 * Assumes all host and mechanism inputs are asynchronous to CLK and that
 * the stepper winding driver and analog read path sit outside.
 */
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module fdpos_top
	import fdpos_pkg::*;
#(
	parameter int STEP_CYC = STEP_CYC_DEF,
	parameter int SETTLE_CYC = SETTLE_CYC_DEF,
	parameter int HEAD_LOAD_CYC = HEAD_LOAD_CYC_DEF
) (
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// host interface pins
	input wire fdpos_host_in_s HOST_IN,
	output fdpos_host_out_s HOST_OUT,
	// mechanism and link to the second unit
	input wire fdpos_mech_in_s MECH_IN,
	output fdpos_mech_out_s MECH_OUT,
	// register port
	input wire logic [REG_AW-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA
);

	// ==========================================================
	// constants at timer width; bit and cell counts at 8 bits
	localparam logic [TMR_W-1:0] STEP_LD = TMR_W'(STEP_CYC - 1);
	localparam logic [TMR_W-1:0] SETTLE_LD = TMR_W'(SETTLE_CYC - 1);
	localparam logic [TMR_W-1:0] HEAD_LD = TMR_W'(HEAD_LOAD_CYC - 1);
	localparam logic [7:0] BIT_LAST = 8'(BIT_CYC - 1);
	localparam logic [7:0] CELL_LAST = 8'(CELL_CYC - 1);

	// ==========================================================
	// input synchronisers
	logic [IN_W-1:0] in_s1_r;
	logic [IN_W-1:0] in_s2_r;
	fdpos_host_in_s hin;
	fdpos_mech_in_s min;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			// idle levels, so no false disk or track 00 right after reset
			in_s1_r <= SYNC_IDLE;
			in_s2_r <= SYNC_IDLE;
		end else begin
			in_s1_r <= {HOST_IN, MECH_IN};
			in_s2_r <= in_s1_r;
		end
	end

	assign hin = fdpos_host_in_s'(in_s2_r[IN_W-1 -: $bits(fdpos_host_in_s)]);
	assign min = fdpos_mech_in_s'(in_s2_r[$bits(fdpos_mech_in_s)-1:0]);

	// ==========================================================
	// register port
	logic ctrl_slave_r;
	logic recal_req_r;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_slave_r <= CTRL_SLAVE_RST;
			recal_req_r <= 1'b0;
		end else begin
			recal_req_r <= REG_WR && REG_ADDR == REG_CTRL && REG_WDATA[CTRL_RECAL_BIT];
			if (REG_WR && REG_ADDR == REG_CTRL) begin
				ctrl_slave_r <= REG_WDATA[CTRL_SLAVE_BIT];
			end
		end
	end

	// ==========================================================
	// seek strobe and unit selection
	logic seek_prev_r;
	logic seek_fall;
	logic seek_rise;
	logic selected;
	logic spin_ok;
	logic ready_r;
	logic seek_go;
	logic [CYL_W-1:0] cyl_latch_r;
	logic illegal_r;

	// high on the select line means the master unit
	assign selected = hin.unit_sel_n ? !ctrl_slave_r : ctrl_slave_r;
	assign spin_ok = min.disk_present && min.spindle_at_speed;
	assign seek_fall = seek_prev_r && !hin.seek_n;
	assign seek_rise = !seek_prev_r && hin.seek_n;
	// trailing edge starts motion only for a legal target
	assign seek_go = seek_rise && selected && ready_r && cyl_latch_r <= CYL_LAST;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			seek_prev_r <= 1'b1;
		end else begin
			seek_prev_r <= hin.seek_n;
		end
	end

	// ==========================================================
	// address latch and range check
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cyl_latch_r <= CYL_ZERO;
		end else if (!spin_ok) begin
			cyl_latch_r <= CYL_ZERO;
		end else if (seek_fall && selected) begin
			cyl_latch_r <= ~hin.cyl_n;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			illegal_r <= 1'b0;
		end else if (!spin_ok) begin
			illegal_r <= 1'b0;
		end else if (seek_rise && selected) begin
			illegal_r <= cyl_latch_r > CYL_LAST;
		end
	end

	// ==========================================================
	// head selection and load timing
	logic head_side_r;
	logic head_load_r;
	logic [TMR_W-1:0] head_tmr_r;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			head_side_r <= 1'b0;
			head_load_r <= 1'b0;
			head_tmr_r <= '0;
		end else if (!ready_r) begin
			head_load_r <= 1'b0;
			head_tmr_r <= '0;
		end else if (seek_rise && selected) begin
			head_side_r <= !hin.head_sel_n;
			head_load_r <= 1'b1;
			head_tmr_r <= HEAD_LD;
		end else if (head_tmr_r != '0) begin
			head_tmr_r <= head_tmr_r - 1'b1;
		end
	end

	// ==========================================================
	// positioner state machine
	fdpos_state_e state_r;
	logic [CNT_W-1:0] cur_cyl_r;
	logic [CNT_W-1:0] tgt_ext;
	logic [TMR_W-1:0] tmr_r;
	logic step_r;
	logic step_up_r;

	assign tgt_ext = {1'b0, cyl_latch_r};

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_r <= ST_OFF;
			ready_r <= 1'b0;
			cur_cyl_r <= CNT_ZERO;
			tmr_r <= '0;
			step_r <= 1'b0;
			step_up_r <= 1'b0;
		end else begin
			step_r <= 1'b0;
			if (!spin_ok) begin
				state_r <= ST_OFF;
				ready_r <= 1'b0;
			end else begin
				case (state_r)
					ST_OFF: begin
						state_r <= ST_RECAL;
						tmr_r <= '0;
					end
					ST_RECAL: begin
						if (min.track00) begin
							cur_cyl_r <= CNT_ZERO;
							ready_r <= 1'b1;
							state_r <= ST_SETTLE;
							tmr_r <= SETTLE_LD;
						end else if (tmr_r != '0) begin
							tmr_r <= tmr_r - 1'b1;
						end else begin
							// counter is meaningless until the sensor is found
							step_r <= 1'b1;
							step_up_r <= 1'b0;
							tmr_r <= STEP_LD;
						end
					end
					ST_STEP: begin
						if (seek_go) begin
							state_r <= (cyl_latch_r == CYL_ZERO) ? ST_RECAL : ST_STEP;
						end else if (tmr_r != '0) begin
							tmr_r <= tmr_r - 1'b1;
						end else if (cur_cyl_r == tgt_ext) begin
							state_r <= ST_SETTLE;
							tmr_r <= SETTLE_LD;
						end else begin
							step_r <= 1'b1;
							step_up_r <= tgt_ext > cur_cyl_r;
							if (tgt_ext > cur_cyl_r) begin
								cur_cyl_r <= cur_cyl_r + CNT_ONE;
							end else begin
								cur_cyl_r <= cur_cyl_r - CNT_ONE;
							end
							tmr_r <= STEP_LD;
						end
					end
					ST_IDLE, ST_SETTLE: begin
						if (seek_go || recal_req_r) begin
							// a zero target recalibrates to recover a lost count
							if (recal_req_r || cyl_latch_r == CYL_ZERO) begin
								state_r <= ST_RECAL;
							end else begin
								state_r <= ST_STEP;
							end
							tmr_r <= '0;
						end else if (state_r == ST_SETTLE) begin
							if (tmr_r != '0) begin
								tmr_r <= tmr_r - 1'b1;
							end else begin
								state_r <= ST_IDLE;
							end
						end
					end
					default: begin
						state_r <= ST_OFF;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// bit strobe generation
	logic [7:0] bit_cnt_r;
	logic bit_tick;
	logic cell_tick;
	logic data_clk_n_r;

	assign bit_tick = bit_cnt_r == BIT_LAST;
	assign cell_tick = bit_cnt_r == CELL_LAST;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			bit_cnt_r <= 8'h00;
			data_clk_n_r <= 1'b1;
		end else begin
			bit_cnt_r <= bit_tick ? 8'h00 : bit_cnt_r + 8'h01;
			if (bit_tick) begin
				data_clk_n_r <= 1'b0;
			end else if (cell_tick) begin
				data_clk_n_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// write path: NRZ to MFM toward the selected unit
	logic write_gate;
	logic read_gate;
	logic wr_prev_r;
	logic wr_data_cell_r;
	logic mfm_wr_r;

	// a protected disk cannot be written even with the enable low
	assign write_gate = ready_r && selected && !hin.wr_en_n && !min.protect_tab;
	assign read_gate = ready_r && selected && !hin.rd_en_n;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wr_prev_r <= 1'b0;
			wr_data_cell_r <= 1'b0;
			mfm_wr_r <= 1'b0;
		end else if (!write_gate) begin
			wr_prev_r <= 1'b0;
			mfm_wr_r <= 1'b0;
		end else if (bit_tick) begin
			// clock cell only between two zeros
			mfm_wr_r <= !wr_prev_r && hin.wr_data_n;
			wr_data_cell_r <= !hin.wr_data_n;
			wr_prev_r <= !hin.wr_data_n;
		end else if (cell_tick) begin
			mfm_wr_r <= wr_data_cell_r;
		end
	end

	// ==========================================================
	// read path: MFM data cell to inverted NRZ
	logic rd_data_n_r;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rd_data_n_r <= 1'b1;
		end else if (!read_gate) begin
			rd_data_n_r <= 1'b1;
		end else if (bit_tick) begin
			// data cell sits in the second half of the bit
			rd_data_n_r <= !min.mfm_rd;
		end
	end

	// ==========================================================
	// status outputs toward the host
	logic settled_n_r;
	logic wr_prot_n_r;
	logic index_n_r;
	logic sector_n_r;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			settled_n_r <= 1'b1;
			wr_prot_n_r <= 1'b1;
			index_n_r <= 1'b1;
			sector_n_r <= 1'b1;
		end else begin
			settled_n_r <= !(ready_r && state_r == ST_IDLE && head_tmr_r == '0
				&& !seek_go && !recal_req_r);
			wr_prot_n_r <= !(selected && min.protect_tab);
			index_n_r <= !(selected && min.index_hole);
			sector_n_r <= !(selected && min.sector_hole);
		end
	end

	always_comb begin
		HOST_OUT.ready_n = !(ready_r && selected);
		HOST_OUT.settled_n = settled_n_r;
		HOST_OUT.wr_prot_n = wr_prot_n_r;
		HOST_OUT.index_n = index_n_r;
		HOST_OUT.sector_n = sector_n_r;
		HOST_OUT.illegal_n = !illegal_r;
		HOST_OUT.fault_n = 1'b1;
		HOST_OUT.data_clk_n = data_clk_n_r;
		HOST_OUT.rd_data_n = rd_data_n_r;
		MECH_OUT.step = step_r;
		MECH_OUT.step_up = step_up_r;
		MECH_OUT.head_load = head_load_r;
		MECH_OUT.head_side = head_side_r;
		MECH_OUT.write_gate = write_gate;
		MECH_OUT.read_gate = read_gate;
		MECH_OUT.mfm_wr = mfm_wr_r;
	end

	// ==========================================================
	// register read data, one cycle after the strobe
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			REG_RDATA <= 32'h00000000;
		end else if (REG_RD && REG_ADDR == REG_CTRL) begin
			REG_RDATA <= {31'h00000000, ctrl_slave_r};
		end else if (REG_RD && REG_ADDR == REG_STAT) begin
			REG_RDATA <= {12'h000, state_r != ST_IDLE, illegal_r, !settled_n_r, ready_r,
				tgt_ext, cur_cyl_r};
		end else begin
			REG_RDATA <= 32'h00000000;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	a_latch_clear_spin: assert property (!spin_ok |=> cyl_latch_r == CYL_ZERO)
		else $error("address latch not cleared without speed");
	a_latch_capture_seek: assert property (seek_fall && selected && spin_ok
		|=> cyl_latch_r == ~$past(hin.cyl_n))
		else $error("address latch missed the seek strobe");
	a_range_error_flag: assert property (seek_rise && selected && spin_ok
		|=> illegal_r == ($past(cyl_latch_r) > CYL_LAST))
		else $error("range error flag wrong after seek");
	a_illegal_no_move: assert property (seek_rise && selected && ready_r
		&& cyl_latch_r > CYL_LAST && state_r == ST_IDLE && !recal_req_r
		|=> state_r == ST_IDLE && !step_r)
		else $error("carriage moved for an illegal cylinder");
	a_fault_held_high: assert property (HOST_OUT.fault_n)
		else $error("positioning fault output went low");
	a_settled_not_ready: assert property (!ready_r |=> settled_n_r)
		else $error("on-track shown while not ready");
	a_single_cyl_step: assert property ($past(state_r) == ST_STEP && $changed(cur_cyl_r)
		|-> step_r && (cur_cyl_r == $past(cur_cyl_r) + CNT_ONE
		|| cur_cyl_r == $past(cur_cyl_r) - CNT_ONE))
		else $error("counter moved by other than one cylinder");
	a_step_direction: assert property (spin_ok && state_r == ST_STEP && tmr_r == '0
		&& !seek_go && cur_cyl_r != tgt_ext
		|=> step_r && step_up_r == $past(tgt_ext > cur_cyl_r))
		else $error("step direction wrong");
	a_settle_before_track: assert property ($fell(settled_n_r)
		|-> $past(state_r, 2) == ST_SETTLE || $past(state_r, 2) == ST_IDLE)
		else $error("on-track without settle");
	a_ready_at_zero: assert property ($rose(ready_r) |-> cur_cyl_r == CNT_ZERO
		&& $past(min.track00))
		else $error("ready without calibration to zero");
	a_zero_recal: assert property (seek_go && cyl_latch_r == CYL_ZERO && spin_ok
		|=> state_r == ST_RECAL)
		else $error("zero target did not recalibrate");
	a_read_gated: assert property (!read_gate |=> rd_data_n_r)
		else $error("read data driven without read enable");
	a_strobe_period: assert property ($fell(data_clk_n_r) |=> (!data_clk_n_r) [*7])
		else $error("bit strobe low time too short");

	c_seek_done: cover property (state_r == ST_SETTLE ##1 state_r == ST_IDLE);
	c_illegal_seek: cover property ($rose(illegal_r));
	c_recal_zero: cover property (seek_go && cyl_latch_r == CYL_ZERO);
	c_write_burst: cover property (write_gate && bit_tick);

endmodule

// file: sim/fdpos_mech_model.sv
/*
 * Carriage, spindle and disk model facing the mechanism side of fdpos_top.
 * Assumes one step pulse per cylinder and holes on a fixed rotation count.
 */
`timescale 1ns/1ps

module fdpos_mech_model
	import fdpos_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// mechanism pins
	input wire fdpos_mech_out_s mech_out,
	output fdpos_mech_in_s mech_in,
	// bench controls
	input wire logic disk_in,
	input wire logic prot_in,
	input wire logic rd_bit,
	input wire logic slip,
	output int pos
);
	int ph;

	// ==========================================================
	// carriage: slip moves it without a step, to miscalibrate
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pos <= 5;
			ph <= 0;
		end else begin
			ph <= (ph == 1999) ? 0 : ph + 1;
			if (slip) begin
				pos <= pos + 1;
			end else if (mech_out.step) begin
				if (mech_out.step_up && pos < 87) begin
					pos <= pos + 1;
				end else if (!mech_out.step_up && pos > 0) begin
					pos <= pos - 1;
				end
			end
		end
	end

	// ==========================================================
	// sensors; no disk means no holes and no read stream
	assign mech_in.disk_present = disk_in;
	assign mech_in.spindle_at_speed = disk_in;
	assign mech_in.track00 = (pos == 0);
	assign mech_in.index_hole = disk_in && ph < 10;
	assign mech_in.sector_hole = disk_in && (ph % 500) >= 200 && (ph % 500) < 205;
	assign mech_in.protect_tab = prot_in;
	assign mech_in.mfm_rd = disk_in && rd_bit;
endmodule

// file: sim/testbench.sv
/*
 * Self-checking bench for fdpos_top: host pins and register port driven by
 * tasks, carriage from fdpos_mech_model. Assumes shortened step and settle counts.
 */
`timescale 1ns/1ps

module testbench;
	import fdpos_pkg::*;
	localparam int STEP_T = 4;
	localparam int SETTLE_T = 8;
	logic clk, nrst, reg_wr, reg_rd, disk_in, prot_in, rd_bit, slip;
	logic [REG_AW-1:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	fdpos_host_in_s host_in;
	fdpos_host_out_s host_out;
	fdpos_mech_in_s mech_in;
	fdpos_mech_out_s mech_out;
	int pos, want_pos, last_n, err_count, n_tests, p, k;
	int tgt[4] = '{10, 3, 87, 1};

	fdpos_top #(.STEP_CYC(STEP_T), .SETTLE_CYC(SETTLE_T), .HEAD_LOAD_CYC(4)) dut_u (
		.CLK(clk), .NRST(nrst), .HOST_IN(host_in), .HOST_OUT(host_out),
		.MECH_IN(mech_in), .MECH_OUT(mech_out), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata)
	);
	fdpos_mech_model model_u (
		.clk(clk), .nrst(nrst), .mech_out(mech_out), .mech_in(mech_in),
		.disk_in(disk_in), .prot_in(prot_in), .rd_bit(rd_bit), .slip(slip), .pos(pos)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ==========================================================
	// helpers
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// bounded wait; last_n keeps the edges it took
	task automatic wait_on(input int sel, input logic v, input int lim);
		int n;
		logic s;
		n = 0;
		forever begin
			tick(1);
			n++;
			case (sel)
				0: s = host_out.ready_n;
				1: s = host_out.settled_n;
				2: s = host_out.data_clk_n;
				3: s = host_out.index_n;
				4: s = host_out.sector_n;
				default: s = (pos == want_pos);
			endcase
			if (s === v) begin
				last_n = n;
				n_tests++;
				return;
			end
			if (n >= lim) begin
				err_count++;
				$display("ERROR wait %0d expected %b seen %b", sel, v, s);
				end_sim();
			end
		end
	endtask

	task automatic reg_write(input logic [REG_AW-1:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [REG_AW-1:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic seek(input int cyl, input logic side, input logic legal);
		@(posedge clk);
		host_in.cyl_n <= ~CYL_W'(cyl);
		host_in.head_sel_n <= ~side;
		host_in.seek_n <= 1'b0;
		repeat (4) @(posedge clk);
		host_in.seek_n <= 1'b1;
		if (legal) wait_on(1, 1'b1, 6);
	endtask

	task automatic slip_by(input int n);
		@(posedge clk);
		slip <= 1'b1;
		repeat (n) @(posedge clk);
		slip <= 1'b0;
	endtask

	// lands just after the clock edge on which the strobe falls
	task automatic align(input logic meas);
		int h;
		wait_on(2, 1'b1, 120);
		h = last_n;
		wait_on(2, 1'b0, 120);
		if (meas) chk("bit period", BIT_CYC, h + last_n);
	endtask

	task automatic count_wr(output int c);
		c = 0;
		repeat (212) begin
			tick(1);
			if (mech_out.mfm_wr !== 1'b0) c++;
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		nrst = 1'b0;
		{reg_wr, reg_rd, disk_in, prot_in, rd_bit, slip} = '0;
		reg_addr = '0;
		reg_wdata = '0;
		host_in = '1;
		err_count = 0;
		n_tests = 0;
		want_pos = 0;
		tick(20);
		chk("host out in reset", 32'h1FF, 32'(host_out));
		chk("mech out in reset", 0, 32'(mech_out));
		@(posedge clk) nrst <= 1'b1;
		tick(5);
		chk("ready without disk", 1, host_out.ready_n);
		@(posedge clk) disk_in <= 1'b1;
		tick(6);
		chk("on-track during recal", 1, host_out.settled_n);
		wait_on(0, 1'b0, 400);
		chk("carriage at 00", 0, pos);
		wait_on(1, 1'b0, 200);
		for (k = 0; k < 4; k++) begin
			want_pos = tgt[k];
			p = pos;
			seek(tgt[k], k[0], 1'b1);
			tick(2 * STEP_T);
			chk("step direction", tgt[k] > p, mech_out.step_up);
			chk("carriage moving", 1, tgt[k] > p ? pos > p : pos < p);
			wait_on(5, 1'b1, 2000);
			wait_on(1, 1'b0, 200);
			chk("settle delay", 1, last_n >= SETTLE_T);
			reg_read(REG_STAT, rv);
			chk("present cylinder", tgt[k], rv[7:0]);
			chk("latched target", tgt[k], rv[15:8]);
			chk("head side", k[0], mech_out.head_side);
			chk("head loaded", 1, mech_out.head_load);
			chk("range legal", 1, host_out.illegal_n);
		end
		for (k = 0; k < 2; k++) begin
			seek(k ? 127 : 88, 1'b0, 1'b0);
			tick(4 * STEP_T);
			chk("range error", 0, host_out.illegal_n);
			chk("carriage held", 1, pos);
			chk("on-track held", 0, host_out.settled_n);
		end
		reg_read(REG_STAT, rv);
		chk("latched illegal", 127, rv[15:8]);
		@(posedge clk) disk_in <= 1'b0;
		tick(6);
		chk("ready after removal", 1, host_out.ready_n);
		chk("range error cleared", 1, host_out.illegal_n);
		reg_read(REG_STAT, rv);
		chk("latch cleared", 0, rv[15:8]);
		slip_by(3);
		@(posedge clk) disk_in <= 1'b1;
		wait_on(0, 1'b0, 400);
		chk("recal after insert", 0, pos);
		wait_on(1, 1'b0, 200);
		slip_by(3);
		want_pos = 0;
		seek(0, 1'b0, 1'b1);
		wait_on(5, 1'b1, 400);
		wait_on(1, 1'b0, 200);
		reg_read(REG_STAT, rv);
		chk("counter after recal", 0, rv[7:0]);
		chk("carriage after recal", 0, pos);
		slip_by(2);
		reg_write(REG_CTRL, 32'h0000_0002);
		wait_on(5, 1'b1, 400);
		wait_on(1, 1'b0, 200);
		reg_read(REG_CTRL, rv);
		chk("recal bit clears", 0, rv);
		@(posedge clk) host_in.unit_sel_n <= 1'b0;
		tick(4);
		chk("ready other unit", 1, host_out.ready_n);
		reg_write(REG_CTRL, 32'h0000_0001);
		tick(4);
		chk("ready as slave", 0, host_out.ready_n);
		reg_read(REG_CTRL, rv);
		chk("ctrl readback", 1, rv);
		@(posedge clk) host_in.unit_sel_n <= 1'b1;
		tick(4);
		chk("ready master addressed", 1, host_out.ready_n);
		reg_write(REG_CTRL, 32'h0000_0000);
		reg_write(4'h8, 32'hFFFF_FFFF);
		reg_read(4'h8, rv);
		chk("unmapped read", 0, rv);
		reg_read(REG_CTRL, rv);
		chk("ctrl after unmapped write", 0, rv);
		@(posedge clk) prot_in <= 1'b1;
		tick(4);
		chk("write protect", 0, host_out.wr_prot_n);
		wait_on(3, 1'b0, 2100);
		wait_on(3, 1'b1, 20);
		wait_on(4, 1'b0, 600);
		wait_on(4, 1'b1, 20);
		@(posedge clk) host_in.wr_en_n <= 1'b0;
		count_wr(p);
		chk("mfm while protected", 0, p);
		chk("write gate protected", 0, mech_out.write_gate);
		@(posedge clk);
		prot_in <= 1'b0;
		host_in.wr_en_n <= 1'b1;
		count_wr(p);
		chk("mfm write disabled", 0, p);
		@(posedge clk) host_in.wr_en_n <= 1'b0;
		for (k = 0; k < 2; k++) begin
			@(posedge clk) host_in.wr_data_n <= ~k[0];
			align(1'b0);
			align(1'b1);
			tick(5);
			chk("clock cell", k == 0, mech_out.mfm_wr);
			tick(53);
			chk("data cell", k[0], mech_out.mfm_wr);
			chk("write gate", 1, mech_out.write_gate);
		end
		@(posedge clk) host_in.wr_en_n <= 1'b1;
		@(posedge clk) host_in.rd_en_n <= 1'b0;
		for (k = 0; k < 3; k++) begin
			@(posedge clk) rd_bit <= (k != 1);
			if (k == 2) host_in.rd_en_n <= 1'b1;
			repeat (3) align(1'b0);
			chk("read data", k != 0, host_out.rd_data_n);
			chk("read gate", k != 2, mech_out.read_gate);
		end
		chk("fault output", 1, host_out.fault_n);
		end_sim();
	end
endmodule
